// *** core/pin_func_pkg.sv ***
// Package of pin function codes, reset values and widths for the pin block.
`default_nettype none
package pin_func_pkg;
    localparam int         SEL_W             = 2;
    // Bidirectional pin functions.
    localparam logic [1:0] BIDIR_STROBE      = 2'h0;
    localparam logic [1:0] BIDIR_CHAIN_OUT   = 2'h1;
    localparam logic [1:0] BIDIR_INPUT       = 2'h2;
    // Input functions.
    localparam logic [1:0] IN_OFF            = 2'h0;
    localparam logic [1:0] IN_ADDR_SEL       = 2'h1;
    localparam logic [1:0] IN_TRIGGER        = 2'h2;
    localparam logic [1:0] IN_STANDBY        = 2'h3;
    // Second input pin has an extra chain-input selection.
    localparam logic [2:0] IN3_CHAIN_IN      = 3'h4;
    // Reset values of the selections and of the pin outputs.
    localparam logic [1:0] FLASH_SEL_RESET   = BIDIR_STROBE;
    localparam logic [1:0] SHUTTER_SEL_RESET = BIDIR_STROBE;
    localparam logic [1:0] IN2_SEL_RESET     = IN_OFF;
    localparam logic [2:0] IN3_SEL_RESET     = 3'h0;
    localparam logic       PIN_OUT_RESET     = 1'b0;
endpackage : pin_func_pkg
`default_nettype wire

// *** core/pin_sync.sv ***
// Two-flop synchroniser bank for the pin inputs.
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge mclk) begin
        if (rst) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : pin_sync
`default_nettype wire

// *** core/sensor_general_pin_functions.sv ***
// Function assignment and power-up state of the four general pins.
`default_nettype none
module sensor_general_pin_functions
    import pin_func_pkg::*;
(
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             shutdown_reset_n,
    input  wire logic             sel_write,
    input  wire logic [SEL_W-1:0] flash_sel_in,
    input  wire logic [SEL_W-1:0] shutter_sel_in,
    input  wire logic [SEL_W-1:0] in2_sel_in,
    input  wire logic [2:0]       in3_sel_in,
    input  wire logic             flash_strobe,
    input  wire logic             shutter_ctrl,
    input  wire logic             chain_out,
    input  wire logic             flash_multi_pin_i,
    output logic                  flash_multi_pin_o,
    output logic                  flash_multi_pin_oe,
    input  wire logic             shutter_multi_pin_i,
    output logic                  shutter_multi_pin_o,
    output logic                  shutter_multi_pin_oe,
    input  wire logic             first_input_pin,
    input  wire logic             second_input_pin,
    output logic                  first_input_en,
    output logic                  second_input_en,
    output logic                  alt_device_address_select,
    output logic                  capture_trigger,
    output logic                  standby_request,
    output logic                  chain_in,
    output logic [SEL_W-1:0]      flash_sel_reg,
    output logic [SEL_W-1:0]      shutter_sel_reg,
    output logic [SEL_W-1:0]      in2_sel_reg,
    output logic [2:0]            in3_sel_reg
);

    ////////////////////////////////////////////////////////////////////////
    // The shutdown pin is asynchronous, so it is synchronised together with
    // the pins; internal reset is the OR of rst and a low shutdown.
    // The pins float two or three cycles after shutdown falls, a price paid
    // so that no flop past the first synchroniser stage sees that pin move close to its clock edge.
    logic [4:0] pins_sync;
    logic       down;

    pin_sync #(.WIDTH(5)) pin_sync_inst (
        .mclk     (mclk),
        .rst      (rst),
        .async_in ({shutdown_reset_n, flash_multi_pin_i,
                    shutter_multi_pin_i, first_input_pin,
                    second_input_pin}),
        .sync_out (pins_sync)
    );

    // A cleared second stage (sync_out) keeps the block in shutdown from rst onward.
    assign down = rst | ~pins_sync[4];

    ////////////////////////////////////////////////////////////////////////
    // Selection fields. All four load on one write strobe, so a pin never
    // runs with half of a new configuration.
    always_ff @(posedge mclk) begin
        if (down) begin
            flash_sel_reg <= FLASH_SEL_RESET;
        end else if (sel_write) begin
            flash_sel_reg <= flash_sel_in;
        end
    end

    always_ff @(posedge mclk) begin
        if (down) begin
            shutter_sel_reg <= SHUTTER_SEL_RESET;
        end else if (sel_write) begin
            shutter_sel_reg <= shutter_sel_in;
        end
    end

    always_ff @(posedge mclk) begin
        if (down) begin
            in2_sel_reg <= IN2_SEL_RESET;
        end else if (sel_write) begin
            in2_sel_reg <= in2_sel_in;
        end
    end

    always_ff @(posedge mclk) begin
        if (down) begin
            in3_sel_reg <= IN3_SEL_RESET;
        end else if (sel_write) begin
            in3_sel_reg <= in3_sel_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input buffers are enabled only for input functions.
    function automatic logic bidir_is_input(input logic [SEL_W-1:0] s);
        return s == BIDIR_INPUT;
    endfunction : bidir_is_input

    logic flash_in_en;
    logic shutter_in_en;
    assign flash_in_en     = bidir_is_input(flash_sel_reg);
    assign shutter_in_en   = bidir_is_input(shutter_sel_reg);
    assign first_input_en  = (in2_sel_reg != IN_OFF);
    assign second_input_en = (in3_sel_reg != 3'h0);

    ////////////////////////////////////////////////////////////////////////
    // Bidirectional pin drive. Output enables fall in shutdown so the pins
    // float; after release they drive flash_strobe and shutter_ctrl in the default strobe role.
    // Output drivers stay powered in their default role.
    always_ff @(posedge mclk) begin
        if (down) begin
            flash_multi_pin_oe <= 1'b0;
        end else begin
            flash_multi_pin_oe <= ~flash_in_en;
        end
    end

    always_ff @(posedge mclk) begin
        if (down || flash_in_en) begin
            flash_multi_pin_o <= PIN_OUT_RESET;
        end else begin
            flash_multi_pin_o <= flash_strobe;
        end
    end

    always_ff @(posedge mclk) begin
        if (down) begin
            shutter_multi_pin_oe <= 1'b0;
        end else begin
            shutter_multi_pin_oe <= ~shutter_in_en;
        end
    end

    always_ff @(posedge mclk) begin
        if (down) begin
            shutter_multi_pin_o <= PIN_OUT_RESET;
        end else begin
            case (shutter_sel_reg)
                BIDIR_STROBE:    shutter_multi_pin_o <= shutter_ctrl;
                BIDIR_CHAIN_OUT: shutter_multi_pin_o <= chain_out;
                default:         shutter_multi_pin_o <= PIN_OUT_RESET;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input functions. Any pin set to an input function feeds it; several
    // sources for one function are ORed, a simple and safe merge.
    function automatic logic uses(input logic [2:0] s, input logic [2:0] f,
                                  input logic en, input logic v);
        return en & (s == f) & v;
    endfunction : uses

    logic [2:0] fsel3;
    logic [2:0] ssel3;
    logic [2:0] i2sel3;
    logic       f_in;
    logic       s_in;
    logic       p2_in;
    logic       p3_in;
    assign fsel3  = {1'b0, flash_sel_reg};
    assign ssel3  = {1'b0, shutter_sel_reg};
    assign i2sel3 = {1'b0, in2_sel_reg};
    assign f_in   = pins_sync[3];
    assign s_in   = pins_sync[2];
    assign p2_in  = pins_sync[1] & first_input_en;
    assign p3_in  = pins_sync[0] & second_input_en;

    // A bidirectional pin set to input carries the address-select role; its
    // selection field has no room to name the other first-pin functions.
    logic addr_next;
    logic trig_next;
    logic stby_next;
    logic chain_next;
    assign addr_next  = uses(i2sel3, {1'b0, IN_ADDR_SEL}, 1'b1, p2_in)
                      | uses(in3_sel_reg, {1'b0, IN_ADDR_SEL}, 1'b1, p3_in)
                      | uses(fsel3, {1'b0, BIDIR_INPUT}, 1'b1, f_in)
                      | uses(ssel3, {1'b0, BIDIR_INPUT}, 1'b1, s_in);
    assign trig_next  = uses(i2sel3, {1'b0, IN_TRIGGER}, 1'b1, p2_in)
                      | uses(in3_sel_reg, {1'b0, IN_TRIGGER}, 1'b1, p3_in);
    assign stby_next  = uses(i2sel3, {1'b0, IN_STANDBY}, 1'b1, p2_in)
                      | uses(in3_sel_reg, {1'b0, IN_STANDBY}, 1'b1, p3_in);
    assign chain_next = uses(in3_sel_reg, IN3_CHAIN_IN, 1'b1, p3_in);

    always_ff @(posedge mclk) begin
        if (down) begin
            alt_device_address_select <= 1'b0;
        end else begin
            alt_device_address_select <= addr_next;
        end
    end

    always_ff @(posedge mclk) begin
        if (down) begin
            capture_trigger <= 1'b0;
        end else begin
            capture_trigger <= trig_next;
        end
    end

    always_ff @(posedge mclk) begin
        if (down) begin
            standby_request <= 1'b0;
        end else begin
            standby_request <= stby_next;
        end
    end

    always_ff @(posedge mclk) begin
        if (down) begin
            chain_in <= 1'b0;
        end else begin
            chain_in <= chain_next;
        end
    end

endmodule : sensor_general_pin_functions
`default_nettype wire

// *** dv/pin_func_properties.sv ***
// Checker of pin drive, selection load and input routing.
`default_nettype none
module pin_func_properties
    import pin_func_pkg::*;
(
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic       shutdown_reset_n,
    input wire logic       sel_write,
    input wire logic       flash_strobe,
    input wire logic       chain_out,
    input wire logic       chain_in,
    input wire logic       first_input_pin,
    input wire logic       second_input_pin,
    input wire logic       flash_multi_pin_o,
    input wire logic       flash_multi_pin_oe,
    input wire logic       shutter_multi_pin_o,
    input wire logic       shutter_multi_pin_oe,
    input wire logic       first_input_en,
    input wire logic       second_input_en,
    input wire logic       alt_device_address_select,
    input wire logic [1:0] flash_sel_in,
    input wire logic [1:0] in2_sel_in,
    input wire logic [2:0] in3_sel_in,
    input wire logic [1:0] flash_sel_reg,
    input wire logic [1:0] shutter_sel_reg,
    input wire logic [1:0] in2_sel_reg,
    input wire logic [2:0] in3_sel_reg
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    shut_default_a: assert property (
        !shutdown_reset_n [*4] |-> !flash_multi_pin_oe && !first_input_en
        && flash_sel_reg == FLASH_SEL_RESET && in3_sel_reg == IN3_SEL_RESET)
        else $error("selection kept in shutdown");
    input_mode_a: assert property (
        flash_sel_reg == BIDIR_INPUT |=> !flash_multi_pin_oe)
        else $error("flash pin driven in input mode");
    strobe_drive_a: assert property (
        flash_multi_pin_oe && $past(flash_sel_reg) == BIDIR_STROBE
        |-> flash_multi_pin_o == $past(flash_strobe)) else $error("bad strobe");
    chain_drive_a: assert property (
        shutter_multi_pin_oe && $past(shutter_sel_reg) == BIDIR_CHAIN_OUT
        |-> shutter_multi_pin_o == $past(chain_out)) else $error("bad chain");
    input_power_a: assert property (
        shutdown_reset_n [*4] ##0 sel_write |=> first_input_en ==
        ($past(in2_sel_in) != IN_OFF) && second_input_en ==
        ($past(in3_sel_in) != IN3_SEL_RESET))
        else $error("input enable wrong");
    sel_load_a: assert property (
        shutdown_reset_n [*4] ##0 sel_write |=> flash_sel_reg ==
        $past(flash_sel_in) && in3_sel_reg == $past(in3_sel_in))
        else $error("selection not loaded");
    addr_route_a: assert property (
        (in2_sel_reg == IN_ADDR_SEL && in3_sel_reg != {1'b0, IN_ADDR_SEL}
        && flash_sel_reg != BIDIR_INPUT && shutter_sel_reg != BIDIR_INPUT)
        [*4] |-> alt_device_address_select == $past(first_input_pin, 3))
        else $error("address select not routed");
    chain_route_a: assert property (
        (in3_sel_reg == IN3_CHAIN_IN) [*4] |-> chain_in ==
        $past(second_input_pin, 3)) else $error("chain input not routed");
endmodule : pin_func_properties
bind sensor_general_pin_functions pin_func_properties
    pin_func_properties_inst (.*);
`default_nettype wire

// *** dv/pin_partner.sv ***
// Far side model: host, flash, shutter and paired sensor on the pins.
`default_nettype none
module pin_partner (
    input  wire logic flash_multi_pin_o,
    input  wire logic flash_multi_pin_oe,
    input  wire logic ext_flash,
    input  wire logic shutter_multi_pin_o,
    input  wire logic shutter_multi_pin_oe,
    input  wire logic ext_shutter,
    input  wire logic ext_first,
    input  wire logic ext_second,
    output logic      flash_multi_pin_i,
    output logic      shutter_multi_pin_i,
    output logic      first_input_pin,
    output logic      second_input_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    // The far side drives a multi pin only once the sensor releases it.
    assign flash_multi_pin_i = flash_multi_pin_oe ? flash_multi_pin_o
                                                  : ext_flash;
    assign shutter_multi_pin_i = shutter_multi_pin_oe ? shutter_multi_pin_o
                                                      : ext_shutter;
    assign first_input_pin = ext_first;
    assign second_input_pin = ext_second;
endmodule : pin_partner
`default_nettype wire

// *** dv/sensor_general_pin_functions_tb.sv ***
// Bench for the general pin function block.
`default_nettype none
module sensor_general_pin_functions_tb import pin_func_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'b0, rst = 1'b1, shutdown_reset_n = 1'b0, sel_write = 1'b0;
    logic flash_strobe = 1'b0, shutter_ctrl = 1'b0, chain_out = 1'b0;
    logic ext_flash = 1'b0, ext_shutter = 1'b0;
    logic ext_first = 1'b0, ext_second = 1'b0;
    logic [1:0] flash_sel_in = 2'h0, shutter_sel_in = 2'h0, in2_sel_in = 2'h0;
    logic [2:0] in3_sel_in = 3'h0;
    logic flash_multi_pin_i, flash_multi_pin_o, flash_multi_pin_oe;
    logic shutter_multi_pin_i, shutter_multi_pin_o, shutter_multi_pin_oe;
    logic first_input_pin, second_input_pin, first_input_en, second_input_en;
    logic alt_device_address_select, capture_trigger, standby_request, chain_in;
    logic [1:0] flash_sel_reg, shutter_sel_reg, in2_sel_reg;
    logic [2:0] in3_sel_reg;
    int errors = 0, tests_run = 0, cycles = 0;
    sensor_general_pin_functions sensor_general_pin_functions_inst (.*);
    pin_partner pin_partner_inst (.*);
    always #12.5 mclk = ~mclk;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish();
        if (errors == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish
    task automatic write_sel(input logic [1:0] f, s, a, input logic [2:0] b);
        {flash_sel_in, shutter_sel_in, in2_sel_in, in3_sel_in} = {f, s, a, b};
        sel_write = 1'b1;
        @(negedge mclk);
        sel_write = 1'b0;
        @(negedge mclk);
    endtask : write_sel
    task automatic t_power_up();
        write_sel(BIDIR_INPUT, BIDIR_INPUT, IN_STANDBY, IN3_CHAIN_IN);
        check({flash_multi_pin_oe, shutter_multi_pin_oe}, 8'h0);
        check({flash_sel_reg, in3_sel_reg}, 8'h0);
        check({first_input_en, second_input_en}, 8'h0);
        shutdown_reset_n = 1'b1;
        repeat (4) @(negedge mclk);
        check({flash_multi_pin_oe, shutter_multi_pin_oe}, 8'h3);
        check({flash_multi_pin_o, shutter_multi_pin_o}, 8'h0);
        check({first_input_en, second_input_en}, 8'h0);
        {flash_strobe, shutter_ctrl} = 2'h3;
        repeat (2) @(negedge mclk);
        check({flash_multi_pin_o, shutter_multi_pin_o}, 8'h3);
    endtask : t_power_up
    task automatic t_outputs();
        write_sel(BIDIR_CHAIN_OUT, BIDIR_CHAIN_OUT, IN_ADDR_SEL, IN3_CHAIN_IN);
        check({first_input_en, second_input_en}, 8'h3);
        {chain_out, shutter_ctrl, ext_first, ext_second} = 4'hB;
        repeat (4) @(negedge mclk);
        check({flash_multi_pin_o, shutter_multi_pin_o}, 8'h3);
        check({alt_device_address_select, chain_in}, 8'h3);
        check({capture_trigger, standby_request}, 8'h0);
    endtask : t_outputs
    task automatic t_inputs();
        {ext_first, ext_second, ext_flash} = 3'h5;
        write_sel(BIDIR_INPUT, BIDIR_INPUT, IN_STANDBY, {1'b0, IN_TRIGGER});
        repeat (3) @(negedge mclk);
        check({flash_multi_pin_oe, shutter_multi_pin_oe}, 8'h0);
        check(alt_device_address_select, 8'h1);
        check({standby_request, capture_trigger}, 8'h2);
        {ext_first, ext_second} = 2'h1;
        repeat (4) @(negedge mclk);
        check({standby_request, capture_trigger}, 8'h1);
    endtask : t_inputs
    task automatic t_cross();
        {ext_first, ext_second, shutter_ctrl} = 3'h7;
        write_sel(BIDIR_STROBE, 2'h3, IN_TRIGGER, {1'b0, IN_ADDR_SEL});
        repeat (3) @(negedge mclk);
        check({capture_trigger, alt_device_address_select}, 8'h3);
        check({shutter_multi_pin_oe, shutter_multi_pin_o}, 8'h2);
        write_sel(BIDIR_STROBE, BIDIR_STROBE, IN_OFF, {1'b0, IN_STANDBY});
        repeat (3) @(negedge mclk);
        check({standby_request, capture_trigger}, 8'h2);
        check({first_input_en, alt_device_address_select}, 8'h0);
    endtask : t_cross
    task automatic t_shutdown();
        shutdown_reset_n = 1'b0;
        repeat (4) @(negedge mclk);
        check({flash_multi_pin_oe, shutter_multi_pin_oe}, 8'h0);
        check({shutter_sel_reg, in2_sel_reg, in3_sel_reg}, 8'h0);
        {flash_strobe, shutter_ctrl} = 2'h0;
        shutdown_reset_n = 1'b1;
        repeat (4) @(negedge mclk);
        check({flash_multi_pin_oe, shutter_multi_pin_oe}, 8'h3);
        check({flash_multi_pin_o, shutter_multi_pin_o}, 8'h0);
        check({first_input_en, second_input_en}, 8'h0);
    endtask : t_shutdown
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 400) begin
            errors++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (5) @(negedge mclk);
        rst = 1'b0;
        t_power_up();
        t_outputs();
        t_inputs();
        t_cross();
        t_shutdown();
        tally_and_finish();
    end
endmodule : sensor_general_pin_functions_tb
`default_nettype wire
